// File: logic/pulse_timer_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "pulse_timer_defs.svh"
module pulse_timer_unit (
	input wire logic i_clk, // System clock, 100 MHz.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic i_wb_cyc, // Bus cycle.
	input wire logic i_wb_stb, // Bus strobe.
	input wire logic i_wb_we, // Bus write.
	input wire logic [7:0] i_wb_adr, // Word address.
	input wire pulse_timer_pkg::word_t i_wb_dat, // Write data.
	input wire logic [1:0] i_wb_sel, // Byte selects.
	output pulse_timer_pkg::word_t o_wb_dat, // Read data.
	output logic o_wb_ack, // Bus acknowledge.
	input wire logic [3:0] i_ext_count_clk, // External clocks A to D.
	input wire logic [15:0] i_cc_pin, // Compare/capture pin levels.
	output logic [15:0] o_cc_pin, // Compare/capture pin drive.
	output logic [15:0] o_cc_oe, // Compare/capture pin enables.
	output logic o_irq, // Interrupt, active high level.
	output logic [5:0] o_dma_req, // DMA request pulse per channel.
	output logic o_adc_trig // A/D start pulse.
);
	import pulse_timer_pkg::*;

	localparam int NCH = `PT_NUM_CH;
	localparam int NREG_OF [NCH] = '{4, 2, 2, 4, 2, 2};
	localparam int PIN_BASE [NCH] = '{0, 4, 6, 8, 12, 14};
	localparam logic [5:0] PHASE_OK = 6'h36;
	localparam logic [5:0] PHASE_CD = 6'h14;
	localparam logic [5:0] STAT_OK [NCH] = '{6'h1F, 6'h33, 6'h33, 6'h1F, 6'h33, 6'h33};
	// Source codes: 0..6 divide by 1,4,16,64,256,1024,4096; 7..A pins; B cascade.
	localparam logic [3:0] SRC_MAP [NCH][8] = '{
		'{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hA},
		'{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'hB},
		'{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9},
		'{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7},
		'{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB},
		'{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'hA}
	};

	word_t ctrl [NCH];
	word_t io [NCH];
	word_t cnt_v [NCH];
	logic [63:0] gen_v [NCH];
	evt_t evt [NCH];
	logic [5:0] status [NCH];
	logic [5:0] mask [NCH];
	logic [5:0] tick, dn, clr_evt, sync_m, cnt_we;
	logic [3:0] gen_we [NCH];
	logic [11:0] pre;
	logic [11:0] src;
	logic [3:0] ext_q, ext_p;
	logic wr_go, sync_wr, sync_clr, any_irq, adc_any;
	word_t rd, wmask, wdat;
	logic [3:0] gi;

	// True when the bus address names register r of channel c.
	function automatic logic hit_reg(input int c, input logic [3:0] r);
		hit_reg = !i_wb_adr[7] && (i_wb_adr[6:4] == c[2:0]) && (i_wb_adr[3:0] == r);
	endfunction : hit_reg

	// A request is taken once, in the cycle before ack rises.
	assign wr_go = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
	assign wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	assign wdat = (rd & ~wmask) | (i_wb_dat & wmask);
	assign gi = i_wb_adr[3:0] - `PT_REG_GEN_A;

	// Read mux; unmapped words read as zero.
	always_comb begin
		rd = '0;
		if (!i_wb_adr[7] && i_wb_adr[6:4] < 3'h6) begin
			case (i_wb_adr[3:0])
				`PT_REG_CTRL: rd = ctrl[i_wb_adr[6:4]];
				`PT_REG_IO: rd = io[i_wb_adr[6:4]];
				`PT_REG_CNT: rd = cnt_v[i_wb_adr[6:4]];
				4'h3, 4'h4, 4'h5, `PT_REG_GEN_D: rd = gen_v[i_wb_adr[6:4]][{gi[1:0], 4'h0} +: 16];
				`PT_REG_STAT: rd = {10'h000, status[i_wb_adr[6:4]]};
				`PT_REG_MASK: rd = {10'h000, mask[i_wb_adr[6:4]]};
				default: rd = '0;
			endcase
		end
	end

	// Ack lasts one cycle and read data is latched with it.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= '0;
		end else begin
			o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
			o_wb_dat <= rd;
		end
	end

	// Free prescaler; divisions by 4 to 4096 are one-cycle enables off it, divide by 1 is always on.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pre <= 12'h000;
		end else begin
			pre <= pre + 12'h001;
		end
	end

	// External pins are synchronous; keep two samples for edges and phases.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_q <= 4'h0;
			ext_p <= 4'h0;
		end else begin
			ext_q <= i_ext_count_clk;
			ext_p <= ext_q;
		end
	end

	// Shared source vector: divided enables then external rising edges.
	assign src[0] = 1'b1;
	assign src[1] = &pre[1:0];
	assign src[2] = &pre[3:0];
	assign src[3] = &pre[5:0];
	assign src[4] = &pre[7:0];
	assign src[5] = &pre[9:0];
	assign src[6] = &pre[11:0];
	assign src[10:7] = ext_q & ~ext_p;
	assign src[11] = 1'b0;

	// A write to any synchronised counter loads them all.
	always_comb begin
		sync_wr = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			sync_wr = sync_wr | (wr_go & hit_reg(c, `PT_REG_CNT) & sync_m[c]);
		end
	end

	assign sync_clr = |(clr_evt & sync_m);

	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			localparam int N = NREG_OF[c];
			localparam int B = PIN_BASE[c];
			localparam int P = (c + 1) % NCH;
			logic [3:0] s;
			logic pa, pb, pa_p, pb_p;

			assign sync_m[c] = ctrl[c][`PT_SYNC_BIT];
			assign cnt_we[c] = (wr_go & hit_reg(c, `PT_REG_CNT)) | (sync_wr & sync_m[c]);
			assign pa = PHASE_CD[c] ? ext_q[2] : ext_q[0];
			assign pb = PHASE_CD[c] ? ext_q[3] : ext_q[1];
			assign pa_p = PHASE_CD[c] ? ext_p[2] : ext_p[0];
			assign pb_p = PHASE_CD[c] ? ext_p[3] : ext_p[1];

			// Pick the count source; phase mode and cascade override the table.
			always_comb begin
				s = SRC_MAP[c][ctrl[c][`PT_CKS_LSB +: 3]];
				tick[c] = src[s];
				dn[c] = 1'b0;
				if (PHASE_OK[c] && ctrl[c][`PT_PHASE_BIT]) begin
					tick[c] = (pa ^ pa_p) | (pb ^ pb_p);
					dn[c] = pa_p ^ pb;
				end else if (s == `PT_SRC_CASC) begin
					tick[c] = evt[P][`PT_OVF_BIT] | evt[P][`PT_UDF_BIT];
					dn[c] = evt[P][`PT_UDF_BIT];
				end
			end

			for (genvar k = 0; k < 4; k++) begin : g_we
				assign gen_we[c][k] = wr_go & (k < N)
					& hit_reg(c, `PT_REG_GEN_A + 4'(k));
			end

			pulse_timer_chan #(
				.NREG(N)
			) u_chan (
				.i_clk(i_clk),
				.i_rst_n(i_rst_n),
				.i_tick(tick[c]),
				.i_dn(dn[c]),
				.i_ctrl(ctrl[c]),
				.i_io(io[c]),
				.i_cnt_we(cnt_we[c]),
				.i_gen_we(gen_we[c]),
				.i_wdat(wdat),
				.i_sync_clr(sync_clr),
				.i_pin(i_cc_pin[B +: N]),
				.o_cnt(cnt_v[c]),
				.o_gen(gen_v[c]),
				.o_evt(evt[c]),
				.o_clr_evt(clr_evt[c]),
				.o_pin(o_cc_pin[B +: N]),
				.o_oe(o_cc_oe[B +: N])
			);
		end
	endgenerate

	// Control, pin set-up and mask registers, byte-lane merged.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int c = 0; c < NCH; c++) begin
				ctrl[c] <= `PT_CTRL_RST;
				io[c] <= `PT_IO_RST;
				mask[c] <= `PT_MASK_RST;
			end
		end else if (wr_go) begin
			for (int c = 0; c < NCH; c++) begin
				if (hit_reg(c, `PT_REG_CTRL)) begin
					ctrl[c] <= wdat;
				end
				if (hit_reg(c, `PT_REG_IO)) begin
					io[c] <= wdat;
				end
				if (hit_reg(c, `PT_REG_MASK)) begin
					mask[c] <= wdat[5:0] & STAT_OK[c];
				end
			end
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int c = 0; c < NCH; c++) begin
				status[c] <= `PT_STAT_RST;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (wr_go && hit_reg(c, `PT_REG_STAT)) begin
					status[c] <= (status[c] & ~(i_wb_dat[5:0] & wmask[5:0]))
						| (evt[c] & STAT_OK[c]);
				end else begin
					status[c] <= status[c] | (evt[c] & STAT_OK[c]);
				end
			end
		end
	end

	// Any unmasked sticky bit holds the interrupt line.
	always_comb begin
		any_irq = 1'b0;
		adc_any = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			any_irq = any_irq | (|(status[c] & mask[c]));
			adc_any = adc_any | (evt[c][0] & ctrl[c][`PT_ADC_BIT]);
		end
	end

	// Register A events become one-cycle DMA and A/D pulses.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
			o_dma_req <= 6'h00;
			o_adc_trig <= 1'b0;
		end else begin
			o_irq <= any_irq;
			o_adc_trig <= adc_any;
			for (int c = 0; c < NCH; c++) begin
				o_dma_req[c] <= evt[c][0] & ctrl[c][`PT_DMA_BIT];
			end
		end
	end
endmodule : pulse_timer_unit
`default_nettype wire

// File: logic/pulse_timer_defs.svh
`ifndef PULSE_TIMER_DEFS_SVH
`define PULSE_TIMER_DEFS_SVH
`define PT_NUM_CH 6
`define PT_REG_CTRL 4'h0
`define PT_REG_IO 4'h1
`define PT_REG_CNT 4'h2
`define PT_REG_GEN_A 4'h3
`define PT_REG_GEN_D 4'h6
`define PT_REG_STAT 4'h7
`define PT_REG_MASK 4'h8
`define PT_CKS_LSB 0
`define PT_CLR_LSB 3
`define PT_PWM_BIT 6
`define PT_PHASE_BIT 7
`define PT_BUF_BIT 8
`define PT_SYNC_BIT 9
`define PT_RUN_BIT 10
`define PT_ADC_BIT 11
`define PT_DMA_BIT 12
`define PT_CAP_BIT 3
`define PT_OVF_BIT 4
`define PT_UDF_BIT 5
`define PT_CTRL_RST 16'h0000
`define PT_IO_RST 16'h0000
`define PT_CNT_RST 16'h0000
`define PT_GEN_RST 16'hFFFF
`define PT_STAT_RST 6'h00
`define PT_MASK_RST 6'h00
`define PT_ACT_LOW 2'h1
`define PT_ACT_HIGH 2'h2
`define PT_ACT_TOG 2'h3
`define PT_SRC_CASC 4'hB
`endif

// File: logic/pulse_timer_pkg.sv
package pulse_timer_pkg;
	typedef logic [15:0] word_t;
	typedef logic [5:0] evt_t;
	typedef enum logic [2:0] {CLR_NONE, CLR_A, CLR_B, CLR_C, CLR_D, CLR_SYNC} clr_sel_t;
endpackage : pulse_timer_pkg

// File: logic/pulse_timer_chan.sv
`timescale 1ns/10ps
`default_nettype none
`include "pulse_timer_defs.svh"
module pulse_timer_chan #(
	parameter int NREG = 4
) (
	input wire logic i_clk, // System clock.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic i_tick, // Count clock enable pulse.
	input wire logic i_dn, // Count down with this tick.
	input wire pulse_timer_pkg::word_t i_ctrl, // Channel control word.
	input wire pulse_timer_pkg::word_t i_io, // Pin and capture control word.
	input wire logic i_cnt_we, // Load the counter.
	input wire logic [3:0] i_gen_we, // Load a general register.
	input wire pulse_timer_pkg::word_t i_wdat, // Write data.
	input wire logic i_sync_clr, // Clear from a synchronised channel.
	input wire logic [NREG-1:0] i_pin, // Capture pin levels.
	output pulse_timer_pkg::word_t o_cnt, // Counter value.
	output logic [63:0] o_gen, // General registers A to D.
	output pulse_timer_pkg::evt_t o_evt, // Underflow, overflow, events D..A.
	output logic o_clr_evt, // Own clear source fired.
	output logic [NREG-1:0] o_pin, // Pin output levels.
	output logic [NREG-1:0] o_oe // Pin output enables.
);
	import pulse_timer_pkg::*;
	clr_sel_t csel;
	logic [3:0] hit, cap, ev;
	logic [NREG-1:0] pin_p;
	logic step, bufm, clr_now, ovf, udf;
	word_t gv [4];

	// Counting only happens on a tick while the channel runs.
	assign step = i_ctrl[`PT_RUN_BIT] & i_tick;
	assign bufm = (NREG == 4) && i_ctrl[`PT_BUF_BIT];
	assign csel = clr_sel_t'(i_ctrl[`PT_CLR_LSB +: 3]);
	assign ev = hit | cap;
	assign clr_now = o_clr_evt | ((csel == CLR_SYNC) & i_sync_clr);
	assign ovf = step & ~i_dn & (&o_cnt) & ~clr_now;
	assign udf = step & i_dn & (o_cnt == 16'h0000) & ~clr_now;
	assign o_evt = {udf, ovf, ev};

	// Own clear source: the selected register's match or capture.
	always_comb begin
		case (csel)
			CLR_A: o_clr_evt = ev[0];
			CLR_B: o_clr_evt = ev[1];
			CLR_C: o_clr_evt = ev[2];
			CLR_D: o_clr_evt = ev[3];
			default: o_clr_evt = 1'b0;
		endcase
	end

	// A bus write wins over a clear so software can always preset the count.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cnt <= `PT_CNT_RST;
		end else if (i_cnt_we) begin
			o_cnt <= i_wdat;
		end else if (clr_now) begin
			o_cnt <= `PT_CNT_RST;
		end else if (step) begin
			o_cnt <= i_dn ? o_cnt - 16'h0001 : o_cnt + 16'h0001;
		end
	end

	// Previous pin levels for edge detection.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_p <= '0;
		end else begin
			pin_p <= i_pin;
		end
	end

	generate
		for (genvar i = 0; i < 4; i++) begin : g_reg
			if (i < NREG) begin : g_on
				word_t r;
				logic [1:0] act;
				logic capm;
				assign act = i_io[4*i +: 2];
				assign capm = i_io[4*i+`PT_CAP_BIT];
				assign cap[i] = capm & ((act[0] & i_pin[i] & ~pin_p[i])
					| (act[1] & ~i_pin[i] & pin_p[i]));
				assign hit[i] = step & ~capm & (o_cnt == r);
				assign gv[i] = r;
				assign o_gen[16*i +: 16] = r;

				// Capture stores the count; buffer mode moves data between A and C and between B and D.
				always_ff @(posedge i_clk or negedge i_rst_n) begin
					if (!i_rst_n) begin
						r <= `PT_GEN_RST;
					end else if (i_gen_we[i]) begin
						r <= i_wdat;
					end else if (cap[i]) begin
						r <= o_cnt;
					end else if (bufm && i < 2 && hit[i]) begin
						r <= gv[i^2];
					end else if (bufm && i >= 2 && cap[i^2]) begin
						r <= gv[i^2];
					end
				end

				// Pin role follows the mode; PWM sets high at period start.
				always_ff @(posedge i_clk or negedge i_rst_n) begin
					if (!i_rst_n) begin
						o_pin[i] <= 1'b0;
						o_oe[i] <= 1'b0;
					end else begin
						o_oe[i] <= ~capm & (i_ctrl[`PT_PWM_BIT] | (act != 2'h0));
						if (capm) begin
							o_pin[i] <= 1'b0;
						end else if (i_ctrl[`PT_PWM_BIT]) begin
							if (clr_now | ovf) begin
								o_pin[i] <= 1'b1;
							end else if (hit[i]) begin
								o_pin[i] <= 1'b0;
							end
						end else if (hit[i]) begin
							case (act)
								`PT_ACT_LOW: o_pin[i] <= 1'b0;
								`PT_ACT_HIGH: o_pin[i] <= 1'b1;
								`PT_ACT_TOG: o_pin[i] <= ~o_pin[i];
								default: o_pin[i] <= o_pin[i];
							endcase
						end
					end
				end
			end else begin : g_off
				assign cap[i] = 1'b0;
				assign hit[i] = 1'b0;
				assign gv[i] = '0;
				assign o_gen[16*i +: 16] = '0;
			end
		end
	endgenerate
endmodule : pulse_timer_chan
`default_nettype wire

// File: test/pulse_timer_unit_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_timer_unit_checker (
	input wire logic i_clk, // Clock.
	input wire logic i_rst_n, // Reset, active low.
	input wire logic i_wb_cyc, // Bus cycle.
	input wire logic i_wb_stb, // Bus strobe.
	input wire logic i_wb_we, // Bus write.
	input wire logic [7:0] i_wb_adr, // Word address.
	input wire pulse_timer_pkg::word_t o_wb_dat, // Read data.
	input wire logic o_wb_ack // Acknowledge.
);
	import pulse_timer_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic rd;
	// A read that the unit takes at this edge.
	assign rd = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
	a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");
	a_ack_next_cycle: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
		else $error("request not answered in the next cycle");
	a_ack_needs_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
		else $error("ack without request");
	a_top_half_zero: assert property ((rd && i_wb_adr[7]) |=> o_wb_dat == 16'h0000)
		else $error("unmapped upper address read nonzero");
	a_chan_range_zero: assert property ((rd && i_wb_adr[6:4] > 3'h5) |=> o_wb_dat == 16'h0000)
		else $error("channel beyond five read nonzero");
	a_reg_range_zero: assert property ((rd && i_wb_adr[3:0] > 4'h8) |=> o_wb_dat == 16'h0000)
		else $error("unmapped register read nonzero");
	a_no_cd_regs: assert property ((rd && i_wb_adr[3:0] inside {4'h5, 4'h6}
		&& !(i_wb_adr[6:4] inside {3'h0, 3'h3})) |=> o_wb_dat == 16'h0000)
		else $error("missing general register read nonzero");
	a_status_width: assert property ((rd && i_wb_adr[3:0] inside {4'h7, 4'h8})
		|=> o_wb_dat[15:6] == 10'h000)
		else $error("status or mask wider than six bits");
endmodule : pulse_timer_unit_checker
bind pulse_timer_unit pulse_timer_unit_checker chk_i (.i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb,
	.i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack);
`default_nettype wire

// File: test/pulse_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_pin_model (
	input wire logic i_clk, // Clock.
	input wire logic i_rst_n, // Reset, active low.
	input wire logic i_step, // Make one encoder step.
	input wire logic i_up, // Direction, A leading B.
	input wire logic i_cd, // Use pair C/D, not A/B.
	input wire logic [15:0] i_cap, // Levels on released pins.
	input wire logic [15:0] i_pin, // Unit pin drive.
	input wire logic [15:0] i_oe, // Unit pin enables.
	output logic [3:0] o_ext, // External clocks A to D.
	output logic [15:0] o_lvl // Resolved pin levels.
);
	logic [1:0] ph;
	logic a;
	logic b;
	// Gray order 00,10,11,01 moves only one phase line per step.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph <= 2'h0;
		end else if (i_step) begin
			ph <= i_up ? ph + 2'h1 : ph - 2'h1;
		end
	end
	assign a = ph[0] ^ ph[1];
	assign b = ph[1];
	// The idle pair rests low so it never counts.
	assign o_ext = i_cd ? {b, a, 2'h0} : {2'h0, b, a};
	// A driven pin shows the unit's level, a released one ours.
	assign o_lvl = (i_oe & i_pin) | (~i_oe & i_cap);
endmodule : pulse_pin_model
`default_nettype wire

// File: test/pulse_timer_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_timer_unit_tb;
	import pulse_timer_pkg::*;
	logic clk, rst_n, cyc, stb, we, step, up, cd, ack, irq, adc;
	logic [7:0] adr;
	logic [1:0] sel;
	logic [3:0] ext;
	logic [5:0] dma;
	logic [15:0] cap, lvl, pin, oe;
	word_t wdat, rdat, q;
	int fail_count = 0;
	int tests_run = 0;
	pulse_timer_unit dut (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_ext_count_clk(ext), .i_cc_pin(lvl), .o_cc_pin(pin),
		.o_cc_oe(oe), .o_irq(irq), .o_dma_req(dma), .o_adc_trig(adc));
	pulse_pin_model far (.i_clk(clk), .i_rst_n(rst_n), .i_step(step), .i_up(up), .i_cd(cd),
		.i_cap(cap), .i_pin(pin), .i_oe(oe), .o_ext(ext), .o_lvl(lvl));
	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Single cycle held until ack is sampled; a lost ack counts as a fault.
	task automatic bus(input logic w, input logic [7:0] a, input word_t d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n == 20) fail_count++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic wr(input logic [2:0] c, input logic [3:0] r, input word_t d);
		bus(1'b1, {1'b0, c, r}, d);
	endtask : wr
	task automatic rdc(input logic [2:0] c, input logic [3:0] r, input word_t e, input string nm);
		bus(1'b0, {1'b0, c, r}, 16'h0000);
		chk(nm, q, e);
	endtask : rdc
	task automatic wait_dma(output int t);
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (dma[0] !== 1'b1 && t < 200);
	endtask : wait_dma
	task automatic one_step;
		@(posedge clk);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : one_step
	// Reset values, holes in the map and mask widths.
	task automatic t_regs;
		for (int r = 0; r < 9; r++) rdc(3'h3, r[3:0], (r > 2 && r < 7) ? 16'hFFFF : 16'h0000, "rst");
		wr(3'h1, 4'h5, 16'h5A5A);
		rdc(3'h1, 4'h5, 16'h0000, "ch1 reg c");
		rdc(3'h6, 4'h0, 16'h0000, "ch6");
		rdc(3'h0, 4'h9, 16'h0000, "reg9");
		bus(1'b0, 8'h80, 16'h0000);
		chk("upper", q, 16'h0000);
		wr(3'h0, 4'h8, 16'hFFFF);
		rdc(3'h0, 4'h8, 16'h001F, "mask0");
		wr(3'h1, 4'h8, 16'hFFFF);
		rdc(3'h1, 4'h8, 16'h0033, "mask1");
		wr(3'h0, 4'h8, 16'h0000);
		wr(3'h1, 4'h8, 16'h0000);
	endtask : t_regs
	// Toggle on match A, clear on A, DMA, A/D and interrupt handling.
	task automatic t_compare;
		int t;
		logic p;
		wr(3'h0, 4'h3, 16'h0009);
		wr(3'h0, 4'h1, 16'h0003);
		wr(3'h0, 4'h8, 16'h0001);
		wr(3'h0, 4'h0, 16'h1C08);
		wait_dma(t);
		p = pin[0];
		chk("adc", adc, 16'h0001);
		wait_dma(t);
		chk("period", t[15:0], 16'h000A);
		chk("toggle", {15'h0000, pin[0]}, {15'h0000, ~p});
		chk("oe", oe[0], 16'h0001);
		chk("irq on", irq, 16'h0001);
		wr(3'h0, 4'h0, 16'h0000);
		wr(3'h0, 4'h8, 16'h0000);
		repeat (3) @(posedge clk);
		chk("irq masked", irq, 16'h0000);
		wr(3'h0, 4'h8, 16'h0001);
		repeat (3) @(posedge clk);
		chk("irq unmasked", irq, 16'h0001);
		wr(3'h0, 4'h7, 16'h0001);
		repeat (3) @(posedge clk);
		chk("irq cleared", irq, 16'h0000);
		rdc(3'h0, 4'h7, 16'h0000, "stat0");
	endtask : t_compare
	// Rising-edge capture fires, the falling edge must not.
	task automatic t_capture;
		wr(3'h1, 4'h1, 16'h0009);
		wr(3'h1, 4'h0, 16'h0400);
		cap[4] <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(3'h1, 4'h7, 16'h0001, "cap rise");
		bus(1'b0, 8'h13, 16'h0000);
		chk("cap val", q == 16'hFFFF, 16'h0000);
		wr(3'h1, 4'h7, 16'h0001);
		cap[4] <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(3'h1, 4'h7, 16'h0000, "cap fall");
		wr(3'h1, 4'h0, 16'h0000);
	endtask : t_capture
	// Each encoder channel on its own pin pair, then down through zero.
	task automatic t_phase;
		logic [2:0] chs [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
		logic [3:0] pair = 4'b0110;
		for (int i = 0; i < 4; i++) begin
			cd <= pair[i];
			up <= 1'b1;
			wr(chs[i], 4'h2, 16'h0000);
			wr(chs[i], 4'h0, 16'h0480);
			repeat (3) one_step;
			wr(chs[i], 4'h0, 16'h0000);
			rdc(chs[i], 4'h2, 16'h0003, "phase up");
		end
		cd <= 1'b0;
		up <= 1'b0;
		wr(3'h1, 4'h7, 16'h003F);
		wr(3'h1, 4'h0, 16'h0480);
		repeat (4) one_step;
		wr(3'h1, 4'h0, 16'h0000);
		rdc(3'h1, 4'h2, 16'hFFFF, "phase down");
		rdc(3'h1, 4'h7, 16'h0020, "underflow");
	endtask : t_phase
	// One count write reaches every synchronised channel.
	task automatic t_sync;
		wr(3'h0, 4'h0, 16'h0200);
		wr(3'h3, 4'h0, 16'h0200);
		wr(3'h0, 4'h2, 16'h1234);
		rdc(3'h3, 4'h2, 16'h1234, "sync");
	endtask : t_sync
	// Main sequence after five cycles of reset.
	initial begin
		{cyc, stb, we, step, cd, rst_n} = 6'h00;
		up = 1'b1;
		adr = 8'h00;
		wdat = 16'h0000;
		sel = 2'h3;
		cap = 16'h0000;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_compare();
		t_capture();
		t_phase();
		t_sync();
		tally_and_finish();
	end
	// Cut a hang short well beyond the expected run.
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
endmodule : pulse_timer_unit_tb
`default_nettype wire
